// ### design/rdisp_pkg.sv
package rdisp_pkg;
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CYCLE_MS = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * CYCLE_MS;
    localparam int BAUD = 9600;
    localparam int BAUD_CYCLES = CLK_HZ / BAUD;
    // Character framing and buffering
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = DATA_BITS + 3;
    localparam int FIFO_DEPTH = 16;
    localparam int NUM_DIGITS = 5;
    localparam int BODY_MAX = 7;
    localparam int HDR_LEN = 4;
    localparam logic [3:0] POS_STX = 4'h0;
    localparam logic [3:0] POS_FILL = 4'h1;
    localparam logic [3:0] POS_ADR_HI = 4'h2;
    localparam logic [3:0] POS_ADR_LO = 4'h3;
    // Characters
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_FILL = 8'h20;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_PLUS = 8'h2B;
    localparam logic [7:0] CH_MINUS = 8'h2D;
    localparam logic [7:0] CH_DOT = 8'h2E;
    localparam logic [7:0] CH_OVER = 8'h2D;
    localparam logic [7:0] CH_E = 8'h45;
    localparam logic [7:0] CH_R = 8'h72;
    // Display addresses, two BCD digits
    localparam logic [7:0] ADDR_CH1 = 8'h01;
    localparam logic [7:0] ADDR_CH2 = 8'h21;
    localparam logic [7:0] ADDR_DEF1 = 8'h05;
    localparam logic [7:0] ADDR_DEF2 = 8'h06;
    // Register map
    localparam logic [7:0] OFS_DISP_TYPE = 8'h00;
    localparam logic [7:0] OFS_DEC = 8'h04;
    localparam logic [7:0] OFS_DEF1 = 8'h08;
    localparam logic [7:0] OFS_DEF2 = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam int DEC1_LSB = 0;
    localparam int DEC2_LSB = 4;
    localparam int DEC_W = 3;
    localparam logic [2:0] DEC_MAX = 3'h4;
    localparam logic [15:0] DTYPE_RST = 16'h0000;
    localparam logic [15:0] DEC_RST = 16'h0000;
    localparam logic [15:0] DEF_RST = 16'h0000;
    typedef enum logic [1:0] {SRC_CH1, SRC_CH2, SRC_DEF1, SRC_DEF2} src_t;
endpackage

// ### design/char_fifo.sv
`timescale 1ns/1ps
module char_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_d = push ? nxt(wr_q) : wr_q;
        rd_d = pop ? nxt(rd_q) : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + (AW+1)'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage needs no reset: nothing reads a slot before it is written
    always_ff @(posedge hclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule // char_fifo

// ### design/serial_tx.sv
`timescale 1ns/1ps
module serial_tx #(
    parameter int BAUD_DIV = rdisp_pkg::BAUD_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Character stream
    input wire logic chr_valid,
    output logic chr_ready,
    input wire logic [7:0] chr_data,
    // Line, idle high
    output logic ser_out,
    output logic busy
);
    localparam int FB = rdisp_pkg::FRAME_BITS;
    localparam int DW = $clog2(BAUD_DIV);

    logic [DW-1:0] div_q, div_d;
    logic [3:0] bit_q, bit_d;
    logic [FB-1:0] shr_q, shr_d;
    logic [7:0] dat_q, dat_d;
    logic act_q, act_d, ser_q, ser_d;
    logic baud_en;

    assign baud_en = div_q == '0;
    assign chr_ready = !act_q;
    assign ser_out = ser_q;
    assign busy = act_q;

    always_comb begin
        div_d = div_q;
        bit_d = bit_q;
        shr_d = shr_q;
        dat_d = dat_q;
        act_d = act_q;
        if (!act_q) begin
            if (chr_valid) begin
                act_d = 1'h1;
                div_d = DW'(BAUD_DIV - 1);
                bit_d = 4'(FB);
                dat_d = chr_data;
                shr_d = {1'h1, ^chr_data, chr_data, 1'h0};
            end
        end else if (baud_en) begin
            div_d = DW'(BAUD_DIV - 1);
            shr_d = {1'h1, shr_q[FB-1:1]};
            bit_d = bit_q - 4'h1;
            if (bit_q == 4'h1) begin
                act_d = 1'h0;
            end
        end else begin
            div_d = div_q - DW'(1);
        end
        ser_d = act_d ? shr_d[0] : 1'h1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= '0;
            bit_q <= '0;
            shr_q <= '1;
            dat_q <= '0;
            act_q <= 1'h0;
            ser_q <= 1'h1;
        end else begin
            div_q <= div_d;
            bit_q <= bit_d;
            shr_q <= shr_d;
            dat_q <= dat_d;
            act_q <= act_d;
            ser_q <= ser_d;
        end
    end

    a_parity_even: assert property (@(posedge hclk) disable iff (!hresetn)
        act_q && bit_q == 4'h2 |-> ser_q == ^dat_q)
        else $error("parity bit is not even parity");
    a_start_low: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(act_q) |-> !ser_q ##1 !ser_q)
        else $error("start bit missing");
    a_idle_high: assert property (@(posedge hclk) disable iff (!hresetn)
        !act_q |-> ser_q)
        else $error("line not idle high");
    a_bit_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        act_q && !baud_en |=> $stable(ser_q))
        else $error("line changed inside a bit time");
endmodule // serial_tx

// ### design/remote_display_tx.sv
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Port only transmits, values sent cyclically
// - Values emitted every 100 ms once configured
// - Eight data bits, even parity, 9600 baud
// - Address 01, 21, 05, 06 selects content
// - System fault sends Err instead of weight
// - Too many digits sends over-range string
// - Per-channel decimal point inserted into weight
// - Default values sent without decimal point
// - Channel 2 only on two-channel variant
// - Only low byte of display type evaluated
// - Default values signed, loadable, reset zero
module remote_display_tx #(
    parameter bit TWO_CH = 1'h1,
    parameter int DISP_DIGITS = 6,
    parameter int TICK_CYCLES = rdisp_pkg::TICK_CYCLES,
    parameter int BAUD_DIV = rdisp_pkg::BAUD_CYCLES,
    parameter int FIFO_DEPTH = rdisp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Process values from the weighing logic
    input wire logic [15:0] gross_ch1,
    input wire logic [15:0] gross_ch2,
    input wire logic system_fault_flag,
    // Serial line to the displays
    output logic ser_out
);
    localparam int BM = rdisp_pkg::BODY_MAX;
    localparam int ND = rdisp_pkg::NUM_DIGITS;
    localparam int TW = $clog2(TICK_CYCLES);

    function automatic int pow10(input int n);
        int r;
        r = 1;
        for (int i = 0; i < n; i++) begin
            r = r * 10;
        end
        return r;
    endfunction

    localparam int OVER_LIM = pow10(DISP_DIGITS - 1);

    function automatic logic [19:0] to_bcd(input logic [16:0] bin);
        logic [19:0] b;
        b = '0;
        for (int i = 16; i >= 0; i--) begin
            for (int d = 0; d < 5; d++) begin
                if (b[4*d +: 4] > 4'h4) begin
                    b[4*d +: 4] = b[4*d +: 4] + 4'h3;
                end
            end
            b = {b[18:0], bin[i]};
        end
        return b;
    endfunction

    function automatic logic [2:0] clamp_dp(input logic [2:0] d);
        return (d > rdisp_pkg::DEC_MAX) ? rdisp_pkg::DEC_MAX : d;
    endfunction

    function automatic logic [7:0] addr_of(input rdisp_pkg::src_t s);
        case (s)
            rdisp_pkg::SRC_CH1: return rdisp_pkg::ADDR_CH1;
            rdisp_pkg::SRC_CH2: return rdisp_pkg::ADDR_CH2;
            rdisp_pkg::SRC_DEF1: return rdisp_pkg::ADDR_DEF1;
            default: return rdisp_pkg::ADDR_DEF2;
        endcase
    endfunction

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} state_t;

    // Registers and bus
    logic wen_q, wen_d;
    logic [7:0] wa_q, wa_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] dtype_q, dtype_d, dec_q, dec_d, def1_q, def1_d, def2_q, def2_d;
    logic ap_sel, enabled, busy_w;
    logic [31:0] status_w;
    // Cycle timer
    logic [TW-1:0] cnt_q, cnt_d;
    logic tick, pend_q, pend_d, clr;
    // Message builder
    state_t state_q, state_d;
    rdisp_pkg::src_t src_q, src_d;
    logic [3:0] idx_q, idx_d, last_idx;
    logic [BM-1:0][7:0] body_q, body_d;
    logic [2:0] blen_q, blen_d;
    logic [7:0] fcnt_q, fcnt_d, push_data, addr_w;
    logic [15:0] val_w;
    logic [16:0] v17, mag_w;
    logic [19:0] bcd_w;
    logic [2:0] dp_w, bi;
    logic fault_w, over_w, push, fifo_rdy;
    // Transmit path
    logic tx_valid, tx_ready, tx_busy;
    logic [7:0] tx_data;

    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    assign hrdata = rdata_q;
    assign ap_sel = hsel && hready && htrans[1] && hsize == 3'h2;
    assign enabled = dtype_q[7:0] != 8'h00;
    assign busy_w = state_q != ST_IDLE || tx_valid || tx_busy;
    assign status_w = {16'h0000, fcnt_q, 5'h00, system_fault_flag, busy_w, enabled};

    always_comb begin
        wen_d = ap_sel && hwrite;
        wa_d = haddr[7:0];
        rdata_d = '0;
        if (ap_sel && !hwrite && haddr[31:8] == 24'h000000) begin
            case (haddr[7:0])
                rdisp_pkg::OFS_DISP_TYPE: rdata_d = {16'h0000, dtype_q};
                rdisp_pkg::OFS_DEC: rdata_d = {16'h0000, dec_q};
                rdisp_pkg::OFS_DEF1: rdata_d = {{16{def1_q[15]}}, def1_q};
                rdisp_pkg::OFS_DEF2: rdata_d = {{16{def2_q[15]}}, def2_q};
                rdisp_pkg::OFS_STATUS: rdata_d = status_w;
                default: rdata_d = '0;
            endcase
        end
        dtype_d = dtype_q;
        dec_d = dec_q;
        def1_d = def1_q;
        def2_d = def2_q;
        if (wen_q) begin
            case (wa_q)
                rdisp_pkg::OFS_DISP_TYPE: dtype_d = hwdata[15:0];
                rdisp_pkg::OFS_DEC: dec_d = hwdata[15:0];
                rdisp_pkg::OFS_DEF1: def1_d = hwdata[15:0];
                rdisp_pkg::OFS_DEF2: def2_d = hwdata[15:0];
                default: dtype_d = dtype_q;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wen_q <= 1'h0;
            wa_q <= '0;
            rdata_q <= '0;
            dtype_q <= rdisp_pkg::DTYPE_RST;
            dec_q <= rdisp_pkg::DEC_RST;
            def1_q <= rdisp_pkg::DEF_RST;
            def2_q <= rdisp_pkg::DEF_RST;
        end else begin
            wen_q <= wen_d && haddr[31:8] == 24'h000000;
            wa_q <= wa_d;
            rdata_q <= rdata_d;
            dtype_q <= dtype_d;
            dec_q <= dec_d;
            def1_q <= def1_d;
            def2_q <= def2_d;
        end
    end

    // A new cycle request that lands on the clearing edge survives
    assign tick = enabled && cnt_q == TW'(TICK_CYCLES - 1);

    always_comb begin
        cnt_d = '0;
        if (enabled && !tick) begin
            cnt_d = cnt_q + TW'(1);
        end
        pend_d = (pend_q && !clr) || tick;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            pend_q <= 1'h0;
        end else begin
            cnt_q <= cnt_d;
            pend_q <= pend_d;
        end
    end

    // Value selection; a fault masks only the weights, never the defaults
    always_comb begin
        case (src_q)
            rdisp_pkg::SRC_CH1: val_w = gross_ch1;
            rdisp_pkg::SRC_CH2: val_w = gross_ch2;
            rdisp_pkg::SRC_DEF1: val_w = def1_q;
            default: val_w = def2_q;
        endcase
        case (src_q)
            rdisp_pkg::SRC_CH1: dp_w = clamp_dp(dec_q[rdisp_pkg::DEC1_LSB +: rdisp_pkg::DEC_W]);
            rdisp_pkg::SRC_CH2: dp_w = clamp_dp(dec_q[rdisp_pkg::DEC2_LSB +: rdisp_pkg::DEC_W]);
            default: dp_w = 3'h0;
        endcase
    end

    assign fault_w = system_fault_flag && (src_q == rdisp_pkg::SRC_CH1 || src_q == rdisp_pkg::SRC_CH2);
    assign v17 = {val_w[15], val_w};
    assign mag_w = val_w[15] ? 17'h00000 - v17 : v17;
    assign bcd_w = to_bcd(mag_w);
    assign over_w = int'(mag_w) >= OVER_LIM;
    assign addr_w = addr_of(src_q);
    assign last_idx = 4'(rdisp_pkg::HDR_LEN) + {1'h0, blen_q};
    assign bi = 3'(idx_q - 4'(rdisp_pkg::HDR_LEN));

    always_comb begin
        int n;
        n = 0;
        state_d = state_q;
        src_d = src_q;
        idx_d = idx_q;
        body_d = body_q;
        blen_d = blen_q;
        fcnt_d = fcnt_q;
        clr = 1'h0;
        case (state_q)
            ST_IDLE: begin
                if (pend_q) begin
                    clr = 1'h1;
                    src_d = rdisp_pkg::SRC_CH1;
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                idx_d = '0;
                state_d = ST_SEND;
                body_d = '0;
                if (fault_w) begin
                    body_d[0] = rdisp_pkg::CH_E;
                    body_d[1] = rdisp_pkg::CH_R;
                    body_d[2] = rdisp_pkg::CH_R;
                    n = 3;
                end else if (over_w) begin
                    for (int i = 0; i <= ND; i++) begin
                        body_d[i] = rdisp_pkg::CH_OVER;
                    end
                    n = ND + 1;
                end else begin
                    body_d[0] = val_w[15] ? rdisp_pkg::CH_MINUS : rdisp_pkg::CH_PLUS;
                    n = 1;
                    for (int p = 0; p < ND; p++) begin
                        body_d[n] = rdisp_pkg::CH_ZERO + {4'h0, bcd_w[4*(ND-1-p) +: 4]};
                        n = n + 1;
                        if (dp_w != 3'h0 && p == ND - 1 - int'(dp_w)) begin
                            body_d[n] = rdisp_pkg::CH_DOT;
                            n = n + 1;
                        end
                    end
                end
                blen_d = 3'(n);
            end
            ST_SEND: begin
                if (fifo_rdy) begin
                    idx_d = idx_q + 4'h1;
                    if (idx_q == last_idx) begin
                        fcnt_d = fcnt_q + 8'h01;
                        state_d = ST_LOAD;
                        case (src_q)
                            rdisp_pkg::SRC_CH1: src_d = TWO_CH ? rdisp_pkg::SRC_CH2 : rdisp_pkg::SRC_DEF1;
                            rdisp_pkg::SRC_CH2: src_d = rdisp_pkg::SRC_DEF1;
                            rdisp_pkg::SRC_DEF1: src_d = rdisp_pkg::SRC_DEF2;
                            default: state_d = ST_IDLE;
                        endcase
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            src_q <= rdisp_pkg::SRC_CH1;
            idx_q <= '0;
            body_q <= '0;
            blen_q <= '0;
            fcnt_q <= '0;
        end else begin
            state_q <= state_d;
            src_q <= src_d;
            idx_q <= idx_d;
            body_q <= body_d;
            blen_q <= blen_d;
            fcnt_q <= fcnt_d;
        end
    end

    // Frame layout; the filler is there for displays that drop one character
    always_comb begin
        case (idx_q)
            rdisp_pkg::POS_STX: push_data = rdisp_pkg::CH_STX;
            rdisp_pkg::POS_FILL: push_data = rdisp_pkg::CH_FILL;
            rdisp_pkg::POS_ADR_HI: push_data = rdisp_pkg::CH_ZERO + {4'h0, addr_w[7:4]};
            rdisp_pkg::POS_ADR_LO: push_data = rdisp_pkg::CH_ZERO + {4'h0, addr_w[3:0]};
            default: push_data = (idx_q == last_idx) ? rdisp_pkg::CH_ETX : body_q[bi];
        endcase
    end

    // The builder stalls on a full buffer, so bursts never drop characters
    assign push = state_q == ST_SEND;

    char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(push),
        .in_ready(fifo_rdy),
        .in_data(push_data),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    serial_tx #(.BAUD_DIV(BAUD_DIV)) u_tx (
        .hclk(hclk),
        .hresetn(hresetn),
        .chr_valid(tx_valid),
        .chr_ready(tx_ready),
        .chr_data(tx_data),
        .ser_out(ser_out),
        .busy(tx_busy)
    );

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_cycle_start: assert property (tick && state_q == ST_IDLE && !pend_q |=> ##1 state_q == ST_LOAD)
        else $error("cycle tick lost");
    a_frame_start: assert property (state_q == ST_LOAD |=> push && push_data == rdisp_pkg::CH_STX)
        else $error("frame does not open with STX");
    a_frame_end: assert property (push && fifo_rdy && idx_q == last_idx |->
        push_data == rdisp_pkg::CH_ETX ##1 state_q != ST_SEND)
        else $error("frame does not close with ETX");
    a_ch2_addr: assert property (push && src_q == rdisp_pkg::SRC_CH2 && idx_q == rdisp_pkg::POS_ADR_HI |->
        push_data == 8'h32)
        else $error("channel 2 address wrong");
    a_err_text: assert property (state_q == ST_LOAD && fault_w |=>
        blen_q == 3'h3 && body_q[0] == rdisp_pkg::CH_E && body_q[2] == rdisp_pkg::CH_R)
        else $error("fault text not Err");
    a_over_text: assert property (state_q == ST_LOAD && !fault_w && over_w |=> body_q[1] == rdisp_pkg::CH_OVER)
        else $error("over-range string missing");
    a_dot_place: assert property (state_q == ST_LOAD && !fault_w && !over_w && dp_w == 3'h2 |=>
        body_q[4] == rdisp_pkg::CH_DOT && blen_q == 3'h7)
        else $error("decimal point misplaced");
    a_def_plain: assert property (state_q == ST_LOAD && src_q == rdisp_pkg::SRC_DEF1 && !over_w |=>
        blen_q == 3'h6)
        else $error("default value carries a point");
    a_no_ch2: assert property (!TWO_CH |-> src_q != rdisp_pkg::SRC_CH2)
        else $error("channel 2 sent on single channel variant");
endmodule // remote_display_tx

// ### verif/display_model.sv
`timescale 1ns/1ps
module display_model #(
    parameter int BAUD_DIV = 4,
    parameter logic [15:0] ADDR = "01"
) (
    // Line from the device
    input wire logic hclk,
    input wire logic ser_in
);
    logic [7:0] buf_q[$];
    logic [7:0] ch;
    logic par;
    logic [7:0] last_fill;
    logic [15:0] last_adr;
    logic [63:0] last_body;
    logic [63:0] shown = '0;
    int frames = 0;
    int hits = 0;
    int bad = 0;
    int idle = 0;
    logic broken = 1'h0;

    // Listen only: a silent line is flagged, never answered
    always @(posedge hclk) begin
        idle = ser_in ? idle + 1 : 0;
        broken = idle > 30 * BAUD_DIV * 11 * 12;
    end

    always begin
        @(negedge ser_in);
        repeat (BAUD_DIV / 2) @(posedge hclk);
        for (int i = 0; i < 9; i++) begin // Data LSB first, then parity
            repeat (BAUD_DIV) @(posedge hclk);
            if (i < 8)
                ch[i] = ser_in;
            else
                par = ser_in;
        end
        repeat (BAUD_DIV) @(posedge hclk);
        if (!ser_in || ^{ch, par})
            bad++; // Even parity and stop bit
        if (ch == 8'h02)
            buf_q = {}; // Start of message
        else if (ch == 8'h03) begin // End of message
            last_fill = buf_q[0];
            last_adr = {buf_q[1], buf_q[2]}; // One leading character skipped
            last_body = '0;
            for (int i = 3; i < buf_q.size(); i++)
                last_body = {last_body[55:0], buf_q[i]};
            frames++;
            if (last_adr == ADDR) begin // Own address only, shown as sent
                shown = last_body;
                hits++;
            end
        end else
            buf_q.push_back(ch);
    end
endmodule // display_model

// ### verif/remote_display_serial_output_tb.sv
`timescale 1ns/1ps
module remote_display_serial_output_tb;
    localparam int TICK = 2500;
    localparam int BDIV = 4;
    typedef struct packed {
        logic [15:0] gross;
        logic [7:0] dec;
        logic fault;
        logic [63:0] body;
    } row_t;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [15:0] gross_ch1 = 16'h0;
    logic [15:0] gross_ch2 = 16'h0;
    logic system_fault_flag = 1'h0;
    logic ser_out;
    logic ser_single;
    logic [31:0] rd;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0;
    int n;
    row_t rows[6] = '{
        '{16'h04D2, 8'h02, 1'h0, "+012.34"},
        '{16'hFFFB, 8'h00, 1'h0, "-00005"},
        '{16'hFF85, 8'h03, 1'h0, "-00.123"},
        '{16'h03E7, 8'h07, 1'h0, "+0.0999"},
        '{16'h4E20, 8'h00, 1'h0, "------"},
        '{16'h0001, 8'h02, 1'h1, "Err"}};
    logic [15:0] sq_adr[3] = '{"21", "05", "06"};
    logic [63:0] sq_body[3] = '{"+001.00", "-00007", "+00012"};

    always #12.5 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;

    remote_display_tx #(.TWO_CH(1'h1), .DISP_DIGITS(5), .TICK_CYCLES(TICK), .BAUD_DIV(BDIV),
        .FIFO_DEPTH(16)) i_remote_display_tx (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .gross_ch1(gross_ch1), .gross_ch2(gross_ch2), .system_fault_flag(system_fault_flag),
        .ser_out(ser_out));
    display_model #(.BAUD_DIV(BDIV), .ADDR("01")) i_display_model (.hclk(hclk), .ser_in(ser_out));
    // Single-channel variant on the same bus, watched by a display set to the channel 2 address
    remote_display_tx #(.TWO_CH(1'h0), .DISP_DIGITS(5), .TICK_CYCLES(TICK), .BAUD_DIV(BDIV),
        .FIFO_DEPTH(16)) i_remote_display_tx_single (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(),
        .gross_ch1(gross_ch1), .gross_ch2(gross_ch2), .system_fault_flag(system_fault_flag),
        .ser_out(ser_single));
    display_model #(.BAUD_DIV(BDIV), .ADDR("21")) i_display_model_single (.hclk(hclk), .ser_in(ser_single));

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
            if (k > 50) begin
                errors++;
                final_report();
            end
        end while (hreadyout !== 1'h1);
    endtask

    // Single word transfer; entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    // Frames seen by the display model: own address only, or all
    task automatic wait_cnt(input bit own, input int want);
        int k;
        k = 0;
        while ((own ? i_display_model.hits : i_display_model.frames) < want) begin
            @(posedge hclk);
            k++;
            if (k > 4 * TICK) begin
                errors++;
                final_report();
            end
        end
    endtask

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        ahb(1'h1, rdisp_pkg::OFS_DISP_TYPE, 32'h1);
        foreach (rows[i]) begin
            ahb(1'h1, rdisp_pkg::OFS_DEC, {24'h0, rows[i].dec});
            gross_ch1 <= rows[i].gross;
            system_fault_flag <= rows[i].fault;
            wait_cnt(1'h1, i_display_model.hits + 2);
            check(i_display_model.shown, rows[i].body);
            $display("row %0d done", i);
        end
        wait_cnt(1'h1, i_display_model.hits + 1);
        t0 = cyc;
        wait_cnt(1'h1, i_display_model.hits + 1);
        check(64'(cyc - t0), 64'(TICK));
        $display("period test done");
        system_fault_flag <= 1'h0;
        gross_ch2 <= 16'h0064;
        ahb(1'h1, rdisp_pkg::OFS_DEC, 32'h21);
        ahb(1'h1, rdisp_pkg::OFS_DEF1, 32'hFFF9);
        ahb(1'h1, rdisp_pkg::OFS_DEF2, 32'h000C);
        wait_cnt(1'h1, i_display_model.hits + 2);
        for (int i = 0; i < 3; i++) begin
            wait_cnt(1'h0, i_display_model.frames + 1);
            check(64'(i_display_model.last_adr), 64'(sq_adr[i]));
            check(i_display_model.last_body, sq_body[i]);
            check(64'(i_display_model.last_fill), 64'(rdisp_pkg::CH_FILL));
        end
        check(64'(i_display_model_single.hits), 64'h0);
        check(64'(i_display_model_single.frames != 0), 64'h1);
        ahb(1'h0, rdisp_pkg::OFS_DEF1, 32'h0);
        check(64'(rd), 64'hFFFFFFF9);
        ahb(1'h0, 8'h20, 32'h0);
        check(64'(rd), 64'h0);
        $display("order test done");
        ahb(1'h1, rdisp_pkg::OFS_DISP_TYPE, 32'hFF00);
        repeat (TICK) @(posedge hclk);
        n = i_display_model.frames;
        repeat (2 * TICK) @(posedge hclk);
        check(64'(i_display_model.frames), 64'(n)); // High byte ignored
        $display("type test done");
        hresetn <= 1'h0;
        repeat (3) @(posedge hclk);
        check(64'(ser_out), 64'h1);
        hresetn <= 1'h1;
        @(posedge hclk);
        ahb(1'h0, rdisp_pkg::OFS_DEF2, 32'h0);
        check(64'(rd), 64'h0);
        ahb(1'h0, rdisp_pkg::OFS_DISP_TYPE, 32'h0);
        check(64'(rd), 64'h0);
        check(64'(i_display_model.bad), 64'h0);
        check(64'(i_display_model_single.bad), 64'h0);
        $display("reset test done");
        final_report();
    end
endmodule // remote_display_serial_output_tb
